//--- rtl/sample_out_pkg.sv
// package: widths, reset values, pin bundle and states of the sample output block
package sample_out_pkg;

  // width of one conversion word on the sample word bus
  localparam int unsigned WORD_W = 8;

  // codes at the two ends of the input range, straight binary
  localparam logic [WORD_W-1:0] CODE_BOTTOM = 8'h00;
  localparam logic [WORD_W-1:0] CODE_TOP    = 8'hFF;

  // value of the output word and held sample after reset
  localparam logic [WORD_W-1:0] WORD_RESET = CODE_BOTTOM;

  // bit positions on the sample word bus
  localparam int unsigned LSB_POS = 0;
  localparam int unsigned MSB_POS = WORD_W - 1;

  // conversion clock level seen before the first edge after reset
  localparam logic CONV_CLK_RESET = 1'b0;

  // output enable level after reset: pins released
  localparam logic DRIVE_RESET = 1'b0;

  // timing: system clock and fastest conversion rate
  localparam int unsigned SYS_CLK_PERIOD_NS  = 50;
  localparam int unsigned MAX_SAMPLE_RATE_HZ = 20_000_000;
  localparam int unsigned MIN_CONV_PERIOD_NS = 1_000_000_000 / MAX_SAMPLE_RATE_HZ;
  // least time rounds up; never below one cycle
  localparam int unsigned MIN_CONV_CYCLES_RAW =
    (MIN_CONV_PERIOD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int unsigned MIN_CONV_CYCLES =
    (MIN_CONV_CYCLES_RAW < 1) ? 1 : MIN_CONV_CYCLES_RAW;

  // pins that arrive from outside the clock domain, carried together
  typedef struct packed {
    logic              conv_clk;   // conversion clock pin
    logic              out_en_n;   // output enable pin, active low
    logic [WORD_W-1:0] level;      // quantised analog_input_voltage
  } pin_in_s;

  localparam int unsigned PIN_IN_W = $bits(pin_in_s);

  // conversion sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_WAIT_FALL = 2'b01,
    ST_HOLD      = 2'b10
  } conv_state_e;

endpackage

//--- rtl/pin_sync.sv
// two flip-flop synchroniser for the pin bundle
`timescale 1ns/1ps
`default_nettype none

module pin_sync
  import sample_out_pkg::*;
(
  // clock, reset, enable
  input  wire logic    clock_i,
  input  wire logic    reset_n_i,
  input  wire logic    ce_i,
  // asynchronous pins in, synchronised pins out
  input  wire pin_in_s async_i,
  output var  pin_in_s sync_o
);

  // state: first and second stage
  typedef struct packed {
    pin_in_s stage1;
    pin_in_s stage2;
  } sync_s;

  sync_s state_q;
  sync_s state_d;

  // first stage feeds only the second stage
  always_comb
  begin
    state_d = state_q;
    if (ce_i)
    begin
      state_d.stage1 = async_i;
      state_d.stage2 = state_q.stage1;
    end
  end

  // reset takes constants only; pins stay released until sampled
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      state_q.stage1 <= '{conv_clk: CONV_CLK_RESET, out_en_n: !DRIVE_RESET, level: WORD_RESET};
      state_q.stage2 <= '{conv_clk: CONV_CLK_RESET, out_en_n: !DRIVE_RESET, level: WORD_RESET};
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign sync_o = state_q.stage2;

endmodule

`default_nettype wire

//--- rtl/sample_out.sv
// sample output stage of an 8-bit converter: sample, publish, tristate drive
`timescale 1ns/1ps
`default_nettype none

module sample_out
  import sample_out_pkg::*;
(
  // clock, reset and clock enable
  input  wire logic              clock_i,
  input  wire logic              reset_n_i,
  input  wire logic              ce_i,
  // pins from the capture side and the analog front end
  input  wire logic              conv_clk_i,
  input  wire logic              out_en_n_i,
  input  wire logic [WORD_W-1:0] analog_input_voltage_i,
  // sample word bus: data and per-pin output enable
  output logic      [WORD_W-1:0] sample_word_bus_o,
  output logic      [WORD_W-1:0] sample_word_bus_oe_o,
  // pulse of one enabled cycle when a new word appears on the bus; held while ce_i is low
  output logic                   word_strobe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // edge decode, used for both edges of the conversion clock

  function automatic logic clk_edge(input logic prev, input logic cur, input logic rising);
    clk_edge = rising ? (!prev && cur) : (prev && !cur);
  endfunction

  // quantised level to output code; clamps keep the ends at all zeros / all ones
  function automatic logic [WORD_W-1:0] to_code(input logic [WORD_W-1:0] level);
    if (level <= CODE_BOTTOM)
      to_code = CODE_BOTTOM;
    else if (level >= CODE_TOP)
      to_code = CODE_TOP;
    else
      to_code = level;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser

  pin_in_s pins_async;
  pin_in_s pins;

  // bundle the pins so they cross together
  assign pins_async = '{conv_clk: conv_clk_i, out_en_n: out_en_n_i,
                        level: analog_input_voltage_i};

  pin_sync u_pin_sync (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .async_i   (pins_async),
    .sync_o    (pins)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    conv_state_e       fsm;        // waiting for a sample or holding one
    logic              clk_prev;   // conversion clock one cycle back
    logic [WORD_W-1:0] held_word;  // sampled code awaiting the rising edge
    logic [WORD_W-1:0] out_word;   // word on the bus
    logic              drive;      // pins driven
    logic              strobe;     // new word this cycle
  } out_state_s;

  out_state_s state_q;
  out_state_s state_d;

  logic fall;
  logic rise;

  // edges of the synchronised conversion clock
  assign fall = clk_edge(state_q.clk_prev, pins.conv_clk, 1'b0);
  assign rise = clk_edge(state_q.clk_prev, pins.conv_clk, 1'b1);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  // a rise with no held sample is ignored, so the first word after reset
  // comes from a full fall-then-rise pair and never from stale data
  always_comb
  begin
    state_d = state_q;
    // the strobe only drops on an enabled cycle, so a stall freezes it too
    if (ce_i)
    begin
      state_d.strobe   = 1'b0;
      state_d.clk_prev = pins.conv_clk;
      state_d.drive = !pins.out_en_n;
      unique case (state_q.fsm)
        ST_WAIT_FALL:
        begin
          if (fall)
          begin
            state_d.held_word = to_code(pins.level);
            state_d.fsm       = ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          if (rise)
          begin
            state_d.out_word = state_q.held_word;
            state_d.strobe   = 1'b1;
            state_d.fsm      = ST_WAIT_FALL;
          end
        end
      endcase
    end
  end

  // synchronous active-low reset; every field to a constant
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      state_q.fsm       <= ST_WAIT_FALL;
      state_q.clk_prev  <= CONV_CLK_RESET;
      state_q.held_word <= WORD_RESET;
      state_q.out_word  <= WORD_RESET;
      state_q.drive     <= DRIVE_RESET;
      state_q.strobe    <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, straight from flip-flops

  assign sample_word_bus_o    = state_q.out_word;
  // all eight pins share one enable flop, so they switch together
  assign sample_word_bus_oe_o = {WORD_W{state_q.drive}};
  assign word_strobe_o        = state_q.strobe;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clock_i);
  endclocking

  // a stalled clock enable freezes everything, so checks pause with it
  default disable iff (!reset_n_i || !ce_i);

  sequence s_sample;
    fall && state_q.fsm == ST_WAIT_FALL;
  endsequence

  sequence s_publish;
    rise && state_q.fsm == ST_HOLD;
  endsequence

  property p_sample_held;
    s_sample |=> state_q.held_word == $past(pins.level) && state_q.fsm == ST_HOLD;
  endproperty
  a_sample_held: assert property (p_sample_held)
    else $error("held word does not match level at falling edge");

  property p_publish;
    s_publish |=> word_strobe_o && sample_word_bus_o == $past(state_q.held_word);
  endproperty
  a_publish: assert property (p_publish)
    else $error("word not published after rising edge");

  property p_strobe_cause;
    word_strobe_o |-> $past(rise) && $past(state_q.fsm) == ST_HOLD;
  endproperty
  a_strobe_cause: assert property (p_strobe_cause)
    else $error("word changed without a rising edge");

  property p_fall_to_word;
    (s_sample ##1 s_publish) |=> sample_word_bus_o == $past(pins.level, 2);
  endproperty
  a_fall_to_word: assert property (p_fall_to_word)
    else $error("published code differs from sampled level");

  property p_bit_order;
    (s_sample ##1 s_publish) |=> sample_word_bus_o[LSB_POS] == $past(pins.level[LSB_POS], 2)
                              && sample_word_bus_o[MSB_POS] == $past(pins.level[MSB_POS], 2);
  endproperty
  a_bit_order: assert property (p_bit_order)
    else $error("bit order on sample word bus is wrong");

  property p_one_per_period;
    word_strobe_o |=> !word_strobe_o;
  endproperty
  a_one_per_period: assert property (p_one_per_period)
    else $error("two words within one conversion period");

  property p_drive_on;
    !pins.out_en_n |=> sample_word_bus_oe_o == {WORD_W{1'b1}};
  endproperty
  a_drive_on: assert property (p_drive_on)
    else $error("pins not driven while output enable low");

  property p_release;
    pins.out_en_n |=> sample_word_bus_oe_o == {WORD_W{1'b0}};
  endproperty
  a_release: assert property (p_release)
    else $error("pins driven while output enable high");

  property p_word_stable;
    !word_strobe_o |-> $stable(sample_word_bus_o);
  endproperty
  a_word_stable: assert property (p_word_stable)
    else $error("word changed outside a publish");

endmodule

`default_nettype wire

//--- testbench/capture_side.sv
// capture-side model: conversion clock, enable, input level, word latch
`timescale 1ns/1ps
`default_nettype none

module capture_side
  import sample_out_pkg::*;
(
  // clock
  input  wire logic              clock_i,
  // from the block
  input  wire logic [WORD_W-1:0] bus_i,
  input  wire logic [WORD_W-1:0] oe_i,
  input  wire logic              strobe_i,
  // to the block, plus the latched word to the bench
  output logic                   conv_clk_o,
  output logic                   out_en_n_o,
  output logic      [WORD_W-1:0] level_o,
  output logic      [WORD_W-1:0] word_o
);
  // idle: clock high, pins released
  initial
  begin
    conv_clk_o = 1'b1;
    out_en_n_o = 1'b1;
    level_o    = 8'h00;
    word_o     = 8'h00;
  end

  always @(posedge clock_i)
  begin
    if (strobe_i && !out_en_n_o && (oe_i === 8'hFF))
    begin
      word_o <= bus_i;
    end
  end

  // whole-cycle levels keep the rate in range
  task automatic convert(input logic [WORD_W-1:0] lvl, input int lo_cyc, input int hi_cyc);
    @(posedge clock_i);
    #1;
    level_o    = lvl;
    conv_clk_o = 1'b0;
    repeat (lo_cyc) @(posedge clock_i);
    #1;
    conv_clk_o = 1'b1;
    repeat (hi_cyc - 1) @(posedge clock_i);
  endtask

  // enable pin, changed just after an edge
  task automatic set_enable(input logic en_n);
    @(posedge clock_i);
    #1;
    out_en_n_o = en_n;
  endtask
endmodule

`default_nettype wire

//--- testbench/adc_parallel_sample_output_tb.sv
// self-checking bench for the sample output block
`timescale 1ns/1ps
`default_nettype none

module adc_parallel_sample_output_tb
  import sample_out_pkg::*;
;
  logic              clock_i;
  logic              reset_n_i;
  logic              ce_i;
  logic              conv_clk;
  logic              out_en_n;
  logic [WORD_W-1:0] level;
  logic [WORD_W-1:0] bus;
  logic [WORD_W-1:0] oe;
  logic              strobe;
  logic [WORD_W-1:0] word;
  int                errors;
  int                tests_run;

  ////////////////////////////////////////////////////////////////////////////////
  // clock, 50 ns period
  initial
  begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  sample_out i_sample_out (
    .clock_i                (clock_i),
    .reset_n_i              (reset_n_i),
    .ce_i                   (ce_i),
    .conv_clk_i             (conv_clk),
    .out_en_n_i             (out_en_n),
    .analog_input_voltage_i (level),
    .sample_word_bus_o      (bus),
    .sample_word_bus_oe_o   (oe),
    .word_strobe_o          (strobe)
  );

  capture_side i_capture_side (
    .clock_i    (clock_i),
    .bus_i      (bus),
    .oe_i       (oe),
    .strobe_i   (strobe),
    .conv_clk_o (conv_clk),
    .out_en_n_o (out_en_n),
    .level_o    (level),
    .word_o     (word)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // compare and verdict
  task automatic check8(input string what, input logic [WORD_W-1:0] exp,
                        input logic [WORD_W-1:0] got);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // bounded wait for the strobe, then word, pulse width and latched copy
  task automatic wait_word(input logic [WORD_W-1:0] exp, input logic [WORD_W-1:0] cap);
    int n;
    // step off the edge so the strobe is never read in the step that launches it
    #2;
    for (n = 0; n < 16 && strobe !== 1'b1; n++)
    begin
      @(posedge clock_i);
      #2;
    end
    if (strobe !== 1'b1)
    begin
      errors++;
      $display("ERROR word_strobe expected 1 seen %b", strobe);
      tally_and_finish();
    end
    else
    begin
      check8("bus", exp, bus);
      @(posedge clock_i);
      #2;
      check8("strobe", 8'h00, {{(WORD_W-1){1'b0}}, strobe});
      check8("captured", cap, word);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic test_reset;
    @(posedge clock_i);
    #2;
    check8("bus", WORD_RESET, bus);
    check8("oe", 8'h00, oe);
    // a rise with no sample held gives no word
    repeat (10)
    begin
      @(posedge clock_i);
      #2;
      check8("strobe", 8'h00, {{(WORD_W-1){1'b0}}, strobe});
    end
    $display("test reset done");
  endtask

  task automatic test_enable;
    i_capture_side.set_enable(1'b0);
    repeat (3) @(posedge clock_i);
    #2;
    check8("oe", 8'hFF, oe);
    i_capture_side.set_enable(1'b1);
    repeat (3) @(posedge clock_i);
    #2;
    check8("oe", 8'h00, oe);
    i_capture_side.set_enable(1'b0);
    repeat (3) @(posedge clock_i);
    $display("test enable done");
  endtask

  task automatic test_codes;
    logic [WORD_W-1:0] codes [5];
    codes = '{CODE_BOTTOM, CODE_TOP, 8'h01, 8'h80, 8'h5A};
    foreach (codes[i])
    begin
      i_capture_side.convert(codes[i], 3, 3);
      wait_word(codes[i], codes[i]);
    end
    $display("test codes done");
  endtask

  task automatic test_rate;
    fork
      begin
        i_capture_side.convert(8'hC3, 1, 1);
        i_capture_side.convert(8'h3C, 1, 1);
      end
      begin
        wait_word(8'hC3, 8'hC3);
        wait_word(8'h3C, 8'h3C);
      end
    join
    $display("test rate done");
  endtask

  // clock enable low mid-conversion: nothing moves, the pending rise is kept
  task automatic test_freeze;
    fork
      i_capture_side.convert(8'hA5, 2, 6);
      begin
        repeat (4) @(posedge clock_i);
        #1;
        ce_i = 1'b0;
        repeat (4)
        begin
          @(posedge clock_i);
          #2;
          check8("frozen bus", 8'h3C, bus);
          check8("frozen strobe", 8'h00, {{(WORD_W-1){1'b0}}, strobe});
        end
        @(posedge clock_i);
        #1;
        ce_i = 1'b1;
      end
    join
    wait_word(8'hA5, 8'hA5);
    $display("test freeze done");
  endtask

  task automatic test_release;
    i_capture_side.set_enable(1'b1);
    i_capture_side.convert(8'h77, 2, 2);
    wait_word(8'h77, 8'hA5);
    check8("oe", 8'h00, oe);
    $display("test release done");
  endtask

  // second reset in mid-run, then a word converted from scratch
  task automatic test_reset_again;
    @(posedge clock_i);
    #1;
    reset_n_i = 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
    reset_n_i = 1'b1;
    @(posedge clock_i);
    #2;
    check8("bus after reset", WORD_RESET, bus);
    check8("oe after reset", 8'h00, oe);
    i_capture_side.convert(8'h99, 2, 2);
    wait_word(8'h99, 8'hA5);
    $display("test reset again done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    errors    = 0;
    tests_run = 0;
    reset_n_i = 1'b0;
    ce_i      = 1'b1;
    repeat (10) @(posedge clock_i);
    #1;
    reset_n_i = 1'b1;
    test_reset();
    test_enable();
    test_codes();
    test_rate();
    test_freeze();
    test_release();
    test_reset_again();
    tally_and_finish();
  end
endmodule

`default_nettype wire
